/* File: flc_map.vh */
`ifndef FLC_MAP_VH
`define FLC_MAP_VH

// register byte offsets
`define FLC_OFS_CTRL      6'h00
`define FLC_OFS_CFG       6'h04
`define FLC_OFS_PRESET    6'h08
`define FLC_OFS_THR_A     6'h0C
`define FLC_OFS_THR_B     6'h10
`define FLC_OFS_COUNT     6'h14
`define FLC_OFS_CAPTURE   6'h18
`define FLC_OFS_STATUS    6'h1C
`define FLC_OFS_DIAG      6'h20

// control register bits
`define FLC_CTRL_SYNC_PERMIT    0
`define FLC_CTRL_CAP_PERMIT     1
`define FLC_CTRL_CMP_PERMIT     2
`define FLC_CTRL_ECHO_A         3
`define FLC_CTRL_ECHO_B         4
`define FLC_CTRL_ENABLE_FORCE   5
`define FLC_CTRL_SYNC_FORCE     6
`define FLC_CTRL_FORCE_A        7
`define FLC_CTRL_FORCE_B        8
`define FLC_CTRL_SUSPEND        9
`define FLC_CTRL_ACK_LO         10
`define FLC_CTRL_WIDTH          13

// configuration register bits
`define FLC_CFG_SYNC_PIN        0
`define FLC_CFG_CAP_PIN         1
`define FLC_CFG_REFLEX_A        2
`define FLC_CFG_REFLEX_B        3
`define FLC_CFG_WIDTH           4

// status register bits
`define FLC_ST_VALIDITY         0
`define FLC_ST_ERROR            1
`define FLC_ST_RUNNING          2
`define FLC_ST_TH_A             3
`define FLC_ST_TH_B             4
`define FLC_ST_FLAG_LO          5
`define FLC_ST_REFLEX_A         8
`define FLC_ST_REFLEX_B         9
`define FLC_ST_OUT_A            10
`define FLC_ST_OUT_B            11

// diagnostic bits
`define FLC_DIAG_THR_ORDER      0
`define FLC_DIAG_BAD_ACCESS     1

// flag indices
`define FLC_FLAG_ROLLOVER       0
`define FLC_FLAG_SYNC           1
`define FLC_FLAG_CAPTURE        2
`define FLC_NUM_FLAGS           3

// reset values and count limits
`define FLC_RST_CTRL      13'h0000
`define FLC_RST_CFG       4'h0
`define FLC_RST_PRESET    32'h00000000
`define FLC_RST_THR_A     32'h00000100
`define FLC_RST_THR_B     32'h00000200
`define FLC_COUNT_MAX     32'h7FFFFFFF
`define FLC_COUNT_MIN     32'h80000000

`endif

/* File: flc_flag.v */
`timescale 1ns/10ps
`include "flc_map.vh"

module flc_flag (
  // clock and reset
  input  wire i_clock,
  input  wire i_rst_n,
  input  wire i_clk_en,
  // event and acknowledge
  input  wire i_set,
  input  wire i_ack,
  // sticky flag
  output wire o_flag
);

  reg flag_q;
  reg ack_prev_q;
  wire ack_rise;

  // only the rising edge clears; a held level does nothing
  assign ack_rise = i_ack & ~ack_prev_q;
  assign o_flag   = flag_q;

  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flag_q     <= 1'b0;
      ack_prev_q <= 1'b0;
    end else if (i_clk_en) begin
      ack_prev_q <= i_ack;
      // set wins over a clear in the same cycle
      if (i_set) begin
        flag_q <= 1'b1;
      end else if (ack_rise) begin
        flag_q <= 1'b0;
      end
    end
  end

endmodule // flc_flag

/* File: flc_free_large_counter.v */
// Local design decisions: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
`include "flc_map.vh"

module flc_free_large_counter (
  // clock and reset
  input  wire        i_clock,
  input  wire        i_rst_n,
  input  wire        i_clk_en,
  // avalon-mm slave
  input  wire [5:0]  i_avs_address,
  input  wire        i_avs_read,
  input  wire        i_avs_write,
  input  wire [31:0] i_avs_writedata,
  output wire [31:0] o_avs_readdata,
  output wire        o_avs_waitrequest,
  // physical counter inputs
  input  wire        i_count_up,
  input  wire        i_count_down,
  input  wire        i_enable_pin,
  input  wire        i_sync_pin,
  input  wire        i_cap_pin,
  // physical outputs
  output wire        o_fast_output_a,
  output wire        o_fast_output_b,
  // status
  output wire        o_threshold_event,
  output wire        o_validity,
  output wire        o_error,
  output wire        o_running
);

  // bus state
  reg  [31:0] readdata_q;
  reg         resp_q;
  wire        req;
  wire        wr_take;
  wire        rd_load;

  // software registers
  reg  [`FLC_CTRL_WIDTH-1:0] ctrl_q;
  reg  [`FLC_CFG_WIDTH-1:0]  cfg_q;
  reg  [31:0] preset_q;
  reg  [31:0] thr_a_q;
  reg  [31:0] thr_b_q;
  reg         bad_access_q;

  // counter state
  reg  [31:0] count_q;
  reg  [31:0] count_d;
  reg  [31:0] capture_q;
  reg         started_q;
  reg         dir_up_q;
  reg         sync_cond_prev_q;
  reg         cap_pin_prev_q;
  reg         wrap_d;

  // compare and outputs
  reg         th_a_q;
  reg         th_b_q;
  reg         th_a_d;
  reg         th_b_d;
  reg         reflex_a_q;
  reg         reflex_b_q;
  reg         fast_a_q;
  reg         fast_b_q;
  reg         event_q;

  wire        enable_cond;
  wire        sync_cond;
  wire        sync_rise;
  wire        cap_event;
  wire        running;
  wire        suspend;
  wire        cmp_permit;
  wire        thr_order_bad;
  wire [1:0]  diag;
  wire [`FLC_NUM_FLAGS-1:0] flag_set;
  wire [`FLC_NUM_FLAGS-1:0] flags;
  wire [31:0] status;

  // one wait cycle, then the request is answered
  assign req               = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~resp_q;
  assign wr_take           = i_avs_write & resp_q;
  assign rd_load           = i_avs_read & ~resp_q;
  assign o_avs_readdata    = readdata_q;

  assign suspend    = ctrl_q[`FLC_CTRL_SUSPEND];
  assign cmp_permit = ctrl_q[`FLC_CTRL_CMP_PERMIT];

  assign enable_cond = i_enable_pin | ctrl_q[`FLC_CTRL_ENABLE_FORCE];
  assign sync_cond   = (cfg_q[`FLC_CFG_SYNC_PIN] & ctrl_q[`FLC_CTRL_SYNC_PERMIT] & i_sync_pin)
                     | ctrl_q[`FLC_CTRL_SYNC_FORCE];
  assign sync_rise   = sync_cond & ~sync_cond_prev_q;

  // free-large starts on the first synchronisation
  assign running = started_q & enable_cond;

  // capture refused while the flag is still up
  assign cap_event = cfg_q[`FLC_CFG_CAP_PIN] & ctrl_q[`FLC_CTRL_CAP_PERMIT]
                   & i_cap_pin & ~cap_pin_prev_q
                   & ~flags[`FLC_FLAG_CAPTURE];

  // software must keep the order; a breach is only reported
  assign thr_order_bad = ($signed(thr_a_q) <= 0) | ($signed(thr_a_q) >= $signed(thr_b_q));
  assign diag          = {bad_access_q, thr_order_bad};
  assign o_error       = |diag;

  // next count
  always @* begin
    count_d = count_q;
    wrap_d  = 1'b0;
    if (sync_rise) begin
      count_d = preset_q;
    end else if (running && i_count_up && !i_count_down) begin
      count_d = count_q + 32'h00000001;
      wrap_d  = (count_q == `FLC_COUNT_MAX);
    end else if (running && i_count_down && !i_count_up) begin
      count_d = count_q - 32'h00000001;
      wrap_d  = (count_q == `FLC_COUNT_MIN);
    end
  end

  // threshold bits: rise on >= counting up, fall on <= counting down
  always @* begin
    th_a_d = th_a_q;
    th_b_d = th_b_q;
    if (!cmp_permit) begin
      th_a_d = 1'b0;
      th_b_d = 1'b0;
    end else if (dir_up_q) begin
      if ($signed(count_q) >= $signed(thr_a_q)) begin
        th_a_d = 1'b1;
      end
      if ($signed(count_q) >= $signed(thr_b_q)) begin
        th_b_d = 1'b1;
      end
    end else begin
      if ($signed(count_q) <= $signed(thr_a_q)) begin
        th_a_d = 1'b0;
      end
      if ($signed(count_q) <= $signed(thr_b_q)) begin
        th_b_d = 1'b0;
      end
    end
  end

  // flag events
  assign flag_set[`FLC_FLAG_ROLLOVER] = wrap_d;
  assign flag_set[`FLC_FLAG_SYNC]     = sync_rise;
  assign flag_set[`FLC_FLAG_CAPTURE]  = cap_event;

  genvar gi;
  generate
    for (gi = 0; gi < `FLC_NUM_FLAGS; gi = gi + 1) begin : g_flag
      flc_flag u_flag (
        .i_clock  (i_clock),
        .i_rst_n  (i_rst_n),
        .i_clk_en (i_clk_en),
        .i_set    (flag_set[gi]),
        .i_ack    (ctrl_q[`FLC_CTRL_ACK_LO + gi]),
        .o_flag   (flags[gi])
      );
    end
  endgenerate

  // counter, capture and direction
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      count_q          <= 32'h00000000;
      capture_q        <= 32'h00000000;
      started_q        <= 1'b0;
      dir_up_q         <= 1'b1;
      sync_cond_prev_q <= 1'b0;
      cap_pin_prev_q   <= 1'b0;
    end else if (i_clk_en) begin
      sync_cond_prev_q <= sync_cond;
      cap_pin_prev_q   <= i_cap_pin;
      count_q          <= count_d;
      if (sync_rise) begin
        started_q <= 1'b1;
      end
      if (running && i_count_up && !i_count_down) begin
        dir_up_q <= 1'b1;
      end else if (running && i_count_down && !i_count_up) begin
        dir_up_q <= 1'b0;
      end
      if (cap_event) begin
        capture_q <= count_q;
      end
    end
  end

  // compare results, reflexes and physical outputs
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      th_a_q     <= 1'b0;
      th_b_q     <= 1'b0;
      reflex_a_q <= 1'b0;
      reflex_b_q <= 1'b0;
      fast_a_q   <= 1'b0;
      fast_b_q   <= 1'b0;
      event_q    <= 1'b0;
    end else if (i_clk_en) begin
      event_q <= 1'b0;
      // suspend leaves the compare results, reflexes and fast pins at their last level; the event output drops to zero
      if (!suspend) begin
        th_a_q     <= th_a_d;
        th_b_q     <= th_b_d;
        event_q    <= (th_a_d ^ th_a_q) | (th_b_d ^ th_b_q);
        reflex_a_q <= cfg_q[`FLC_CFG_REFLEX_A] & th_a_d;
        reflex_b_q <= cfg_q[`FLC_CFG_REFLEX_B] & th_b_d;
        fast_a_q   <= cfg_q[`FLC_CFG_REFLEX_A]
                    & ((ctrl_q[`FLC_CTRL_ECHO_A] & th_a_d)
                    | ctrl_q[`FLC_CTRL_FORCE_A]);
        fast_b_q   <= cfg_q[`FLC_CFG_REFLEX_B]
                    & ((ctrl_q[`FLC_CTRL_ECHO_B] & th_b_d)
                    | ctrl_q[`FLC_CTRL_FORCE_B]);
      end
    end
  end

  assign o_fast_output_a   = fast_a_q;
  assign o_fast_output_b   = fast_b_q;
  assign o_threshold_event = event_q;
  assign o_validity        = started_q;
  assign o_running         = running;

  // status word
  assign status = {20'h00000,
                   fast_b_q, fast_a_q,
                   reflex_b_q, reflex_a_q,
                   flags,
                   th_b_q, th_a_q,
                   running, o_error, started_q};

  // register writes
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_q       <= `FLC_RST_CTRL;
      cfg_q        <= `FLC_RST_CFG;
      preset_q     <= `FLC_RST_PRESET;
      thr_a_q      <= `FLC_RST_THR_A;
      thr_b_q      <= `FLC_RST_THR_B;
      bad_access_q <= 1'b0;
    end else if (i_clk_en) begin
      if (wr_take) begin
        case (i_avs_address)
          `FLC_OFS_CTRL: begin
            ctrl_q <= i_avs_writedata[`FLC_CTRL_WIDTH-1:0];
          end
          `FLC_OFS_CFG: begin
            cfg_q <= i_avs_writedata[`FLC_CFG_WIDTH-1:0];
          end
          `FLC_OFS_PRESET: begin
            preset_q <= i_avs_writedata;
          end
          `FLC_OFS_THR_A: begin
            thr_a_q <= i_avs_writedata;
          end
          `FLC_OFS_THR_B: begin
            thr_b_q <= i_avs_writedata;
          end
          `FLC_OFS_DIAG: begin
            // write one to clear the access fault
            if (i_avs_writedata[`FLC_DIAG_BAD_ACCESS]) begin
              bad_access_q <= 1'b0;
            end
          end
          default: begin
            bad_access_q <= 1'b1;
          end
        endcase
      end else if (i_avs_read && resp_q) begin
        case (i_avs_address)
          `FLC_OFS_CTRL, `FLC_OFS_CFG, `FLC_OFS_PRESET, `FLC_OFS_THR_A, `FLC_OFS_THR_B,
          `FLC_OFS_COUNT, `FLC_OFS_CAPTURE, `FLC_OFS_STATUS, `FLC_OFS_DIAG: begin
            bad_access_q <= bad_access_q;
          end
          default: begin
            bad_access_q <= 1'b1;
          end
        endcase
      end
    end
  end

  // bus answer and read data
  always @(posedge i_clock or negedge i_rst_n) begin
    if (!i_rst_n) begin
      resp_q     <= 1'b0;
      readdata_q <= 32'h00000000;
    end else if (i_clk_en) begin
      resp_q <= req & ~resp_q;
      if (rd_load) begin
        case (i_avs_address)
          `FLC_OFS_CTRL:    readdata_q <= {19'h0, ctrl_q};
          `FLC_OFS_CFG:     readdata_q <= {28'h0000000, cfg_q};
          `FLC_OFS_PRESET:  readdata_q <= preset_q;
          `FLC_OFS_THR_A:   readdata_q <= thr_a_q;
          `FLC_OFS_THR_B:   readdata_q <= thr_b_q;
          `FLC_OFS_COUNT:   readdata_q <= count_q;
          `FLC_OFS_CAPTURE: readdata_q <= capture_q;
          `FLC_OFS_STATUS:  readdata_q <= status;
          `FLC_OFS_DIAG:    readdata_q <= {30'h0, diag};
          default:          readdata_q <= 32'h00000000;
        endcase
      end
    end
  end

endmodule // flc_free_large_counter

/* File: flc_field_model.sv */
`timescale 1ns/10ps
module flc_field_model (
  // clock
  input  wire i_clock,
  // count lines
  output reg  o_count_up,
  output reg  o_count_down
);
  // gap cycle between pulses, as a filtered line would give
  task pulses(input integer n, input up);
    integer k;
    begin
      for (k = 0; k < n; k = k + 1) begin
        @(posedge i_clock);
        o_count_up   <= up;
        o_count_down <= !up;
        @(posedge i_clock);
        o_count_up   <= 1'b0;
        o_count_down <= 1'b0;
      end
    end
  endtask
  initial begin
    o_count_up   = 1'b0;
    o_count_down = 1'b0;
  end
endmodule // flc_field_model

/* File: flc_free_large_counter_checker.sv */
`timescale 1ns/10ps
module flc_free_large_counter_checker (
  // clock and reset
  input wire        i_clock,
  input wire        i_rst_n,
  input wire        i_clk_en,
  // bus
  input wire [5:0]  i_avs_address,
  input wire        i_avs_read,
  input wire        i_avs_write,
  input wire [31:0] o_avs_readdata,
  input wire        o_avs_waitrequest,
  // status
  input wire        i_enable_pin,
  input wire        o_validity,
  input wire        o_running,
  input wire        o_error
);
  wire req  = i_avs_read | i_avs_write;
  wire done = req & !o_avs_waitrequest;
  wire bad  = done & (i_avs_address == 6'h3C);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  AST_BUS_IDLE: assert property (!req |-> !o_avs_waitrequest)
    else $error("wait without request");
  AST_BUS_FIRST: assert property ($rose(req) |-> o_avs_waitrequest)
    else $error("no wait cycle");
  AST_BUS_DONE: assert property (req && o_avs_waitrequest && i_clk_en |=> !o_avs_waitrequest)
    else $error("answer late");
  AST_BUS_ONE: assert property (done |=> !done)
    else $error("answer too long");
  AST_BAD_ERR: assert property (bad |=> o_error)
    else $error("no error on bad access");
  AST_BAD_READ: assert property (bad && i_avs_read |-> o_avs_readdata == 32'h00000000)
    else $error("bad read not zero");
  AST_RUN_VALID: assert property (o_running |-> o_validity)
    else $error("running while invalid");
  AST_PIN_RUN: assert property (o_validity && i_enable_pin |-> o_running)
    else $error("enable pin ignored");
  AST_VALID_HOLD: assert property (o_validity |=> o_validity)
    else $error("validity dropped");
  cover property ($rose(o_validity));
  cover property (bad);
  cover property ($fell(o_running));
endmodule // flc_free_large_counter_checker
bind flc_free_large_counter flc_free_large_counter_checker u_chk (
  .i_clock           (i_clock),
  .i_rst_n           (i_rst_n),
  .i_clk_en          (i_clk_en),
  .i_avs_address     (i_avs_address),
  .i_avs_read        (i_avs_read),
  .i_avs_write       (i_avs_write),
  .o_avs_readdata    (o_avs_readdata),
  .o_avs_waitrequest (o_avs_waitrequest),
  .i_enable_pin      (i_enable_pin),
  .o_validity        (o_validity),
  .o_running         (o_running),
  .o_error           (o_error)
);

/* File: tb_flc_free_large_counter.sv */
`timescale 1ns/10ps
`define CHK(a, e) begin checked = checked + 1; if ((a) !== (e)) begin err_total = err_total + 1; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, e); end end
module tb_flc_free_large_counter;
  reg         i_clock, i_rst_n, rd, wr, en_pin, sy, cp, ce;
  reg  [5:0]  adr;
  reg  [31:0] wd, rdv;
  integer     err_total, checked, ev_cnt;
  wire        wq, cu, cd, fa, fb, ev, vl, er, rn;
  wire [31:0] rdat;
  flc_free_large_counter dut (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_clk_en(ce),
    .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wd),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wq), .i_count_up(cu), .i_count_down(cd),
    .i_enable_pin(en_pin), .i_sync_pin(sy), .i_cap_pin(cp), .o_fast_output_a(fa),
    .o_fast_output_b(fb), .o_threshold_event(ev), .o_validity(vl), .o_error(er), .o_running(rn));
  flc_field_model fm (.i_clock(i_clock), .o_count_up(cu), .o_count_down(cd));
  // event is a one-cycle registered pulse, so each edge sees it at most once
  always @(posedge i_clock) begin
    if (!i_rst_n) ev_cnt <= 0;
    else if (ev === 1'b1) ev_cnt <= ev_cnt + 1;
  end
  initial begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end
  task conclude; begin
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  end endtask
  task idle(input integer n); repeat (n) @(negedge i_clock); endtask
  // waitrequest only moves after a rising edge, so the falling edge shows what the next rise samples
  task acc(input w, input [5:0] a, input [31:0] d);
    integer k;
    begin
      @(posedge i_clock);
      adr <= a;
      wd  <= d;
      wr  <= w;
      rd  <= !w;
      k = 0;
      do begin
        @(negedge i_clock);
        k = k + 1;
      end while (wq !== 1'b0 && k < 40);
      if (k >= 40) begin
        err_total = err_total + 1;
        conclude;
      end
      // the rising edge that sees waitrequest low completes the transfer
      @(posedge i_clock);
      rdv = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      @(negedge i_clock);
    end
  endtask
  task pulse_pin(input s); begin
    @(posedge i_clock);
    if (s) sy <= 1'b1;
    else cp <= 1'b1;
    @(posedge i_clock);
    sy <= 1'b0;
    cp <= 1'b0;
    idle(3);
  end endtask
  task t_reset; begin
    acc(0, 6'h0C, 0);
    `CHK(rdv, 32'h00000100)
    acc(0, 6'h1C, 0);
    `CHK(rdv, 32'h00000000)
    acc(0, 6'h3C, 0);
    `CHK(er, 1'b1)
    acc(0, 6'h20, 0);
    `CHK(rdv, 32'h00000002)
    acc(1, 6'h20, 32'h00000002);
    `CHK(er, 1'b0)
    $display("test reset done");
  end endtask
  task t_sync; begin
    acc(1, 6'h08, 32'h00000005);
    acc(1, 6'h00, 32'h00000060);
    idle(2);
    `CHK(vl, 1'b1)
    `CHK(rn, 1'b1)
    acc(0, 6'h14, 0);
    `CHK(rdv, 32'h00000005)
    acc(0, 6'h1C, 0);
    `CHK(rdv[6], 1'b1)
    acc(1, 6'h00, 32'h00000860);
    acc(1, 6'h00, 32'h00000060);
    acc(0, 6'h1C, 0);
    `CHK(rdv[6], 1'b0)
    acc(1, 6'h00, 32'h00000040);
    `CHK(rn, 1'b0)
    @(posedge i_clock) en_pin <= 1'b1;
    idle(1);
    `CHK(rn, 1'b1)
    $display("test sync done");
  end endtask
  task t_cmp; begin
    acc(1, 6'h0C, 32'h00000008);
    acc(1, 6'h10, 32'h0000000C);
    acc(1, 6'h04, 32'h0000000C);
    acc(1, 6'h00, 32'h0000007C);
    fm.pulses(5, 1'b1);
    idle(2);
    acc(0, 6'h1C, 0);
    `CHK(rdv[11:8], 4'h5)
    `CHK(rdv[4:3], 2'h1)
    `CHK({fb, fa}, 2'h1)
    `CHK(ev_cnt, 1)
    acc(1, 6'h00, 32'h0000017C);
    idle(1);
    `CHK(fb, 1'b1)
    acc(1, 6'h00, 32'h0000027C);
    fm.pulses(5, 1'b1);
    idle(2);
    `CHK(fb, 1'b1)
    acc(0, 6'h1C, 0);
    `CHK(rdv[4:3], 2'h1)
    `CHK(ev_cnt, 1)
    acc(1, 6'h00, 32'h0000007C);
    idle(2);
    `CHK({fb, fa}, 2'h3)
    fm.pulses(4, 1'b0);
    idle(2);
    acc(0, 6'h1C, 0);
    `CHK(rdv[4:3], 2'h1)
    acc(1, 6'h00, 32'h00000078);
    idle(2);
    `CHK({fb, fa}, 2'h0)
    `CHK(ev_cnt, 4)
    $display("test compare done");
  end endtask
  task t_cap; begin
    pulse_pin(0);
    acc(0, 6'h1C, 0);
    `CHK(rdv[7], 1'b0)
    acc(1, 6'h04, 32'h0000000E);
    acc(1, 6'h00, 32'h00000062);
    pulse_pin(0);
    acc(0, 6'h18, 0);
    `CHK(rdv, 32'h0000000B)
    fm.pulses(3, 1'b1);
    pulse_pin(0);
    acc(0, 6'h18, 0);
    `CHK(rdv, 32'h0000000B)
    acc(1, 6'h00, 32'h00001062);
    acc(1, 6'h00, 32'h00000062);
    pulse_pin(0);
    acc(0, 6'h18, 0);
    `CHK(rdv, 32'h0000000E)
    $display("test capture done");
  end endtask
  task t_roll; begin
    acc(1, 6'h08, 32'h7FFFFFFE);
    acc(1, 6'h04, 32'h00000001);
    acc(1, 6'h00, 32'h00000021);
    pulse_pin(1);
    acc(0, 6'h14, 0);
    `CHK(rdv, 32'h7FFFFFFE)
    fm.pulses(2, 1'b1);
    idle(1);
    acc(0, 6'h1C, 0);
    `CHK(rdv[5], 1'b1)
    acc(1, 6'h00, 32'h00000421);
    acc(0, 6'h1C, 0);
    `CHK(rdv[5], 1'b0)
    // clock enable low must freeze the counter against count pulses
    @(posedge i_clock) ce <= 1'b0;
    fm.pulses(2, 1'b1);
    @(posedge i_clock) ce <= 1'b1;
    acc(0, 6'h14, 0);
    `CHK(rdv, 32'h80000000)
    $display("test rollover done");
  end endtask
  initial begin
    err_total = 0;
    checked   = 0;
    i_rst_n   = 1'b0;
    {rd, wr, en_pin, sy, cp} = 5'h00;
    ce  = 1'b1;
    adr = 6'h00;
    wd  = 32'h00000000;
    repeat (12) @(posedge i_clock);
    i_rst_n <= 1'b1;
    t_reset;
    t_sync;
    t_cmp;
    t_cap;
    t_roll;
    conclude;
  end
endmodule // tb_flc_free_large_counter
